// *** hdl/mbs_status_gen.sv ***
// message block status word generator with axi4-lite registers
// assumes protocol engine events are synchronous one-cycle pulses
module mbs_status_gen
   import mbs_pkg::*;
#(
   parameter int BUF_PTR_W = 12
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // protocol engine
   input  wire mbs_evt_s    evt,
   output logic [15:0]      status_word,
   output logic             status_wr,
   output logic [BUF_PTR_W-1:0] buf_ptr,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // interrupt
   output logic             irq
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [15:0]          word_q;
   logic [31:0]          cfg_q;
   logic [15:0]          irq_q;
   logic [15:0]          mask_q;
   mbs_state_e           state_q;
   logic [15:0]          gap_q;
   logic [BUF_PTR_W-1:0] ptr_q;
   logic [BUF_PTR_W-1:0] msg_base_q;
   logic                 wrap_pend_q;
   logic                 aw_q, w_q;
   logic [7:0]           awa_q;
   logic [31:0]          wd_q;
   logic [3:0]           ws_q;
   logic                 wr_fire;
   logic                 mon_mode, rollover_on_valid_only, gap_on, bc_off;
   logic [2:0]           size_sel;
   logic [BUF_PTR_W-1:0] buf_top;
   logic                 ptr_at_top;
   logic [15:0]          set_bits;
   logic                 early_resp;
   logic                 end_q;

   assign mon_mode = cfg_q[MBS_C_MON];
   assign rollover_on_valid_only    = cfg_q[MBS_C_ROLLOVER_ON_VALID_ONLY];
   assign gap_on   = cfg_q[MBS_C_GAP];
   assign bc_off   = cfg_q[MBS_C_BCOFF];
   assign size_sel = cfg_q[MBS_C_SIZE_LO+2:MBS_C_SIZE_LO];

   // ----------------------------------------------------------------
   // circular buffer sizing
   // ----------------------------------------------------------------
   // in monitor mode the size is 256 words shifted by the field
   always_comb begin
      if (mon_mode)
         buf_top = BUF_PTR_W'((MBS_BUF_BASE << size_sel) - 1);
      else
         buf_top = '1;
   end
   assign ptr_at_top = (ptr_q == buf_top);

   // ----------------------------------------------------------------
   // message sequencer and response gap timer
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= MBS_IDLE;
         gap_q   <= 16'h0000;
      end else begin
         unique case (state_q)
            MBS_IDLE:    if (evt.msg_start) state_q <= MBS_MSG;
            MBS_MSG: begin
               if (evt.msg_end)
                  state_q <= MBS_IDLE;
               else if (evt.rt_to_rt) begin
                  state_q <= MBS_GAPWAIT;
                  gap_q   <= 16'h0000;
               end
            end
            MBS_GAPWAIT: begin
               gap_q <= gap_q + 16'h0001;
               if (evt.msg_end)
                  state_q <= MBS_IDLE;
               else if (evt.resp_sync_seen)
                  state_q <= MBS_MSG;
            end
         endcase
      end
   end
   // rt_to_rt pulse marks mid-parity of the receive command word
   assign early_resp = gap_on && state_q == MBS_GAPWAIT &&
                       evt.resp_sync_seen &&
                       gap_q < 16'(MBS_GAP_CYC);

   // ----------------------------------------------------------------
   // status word accumulation
   // ----------------------------------------------------------------
   always_comb begin
      set_bits = 16'h0000;
      set_bits[MBS_B_LOOP] = !mon_mode &&
                             (evt.loop_word_bad || evt.loop_mismatch);
      set_bits[MBS_B_ILL]  = !mon_mode && evt.illegal_cmd;
      set_bits[MBS_B_WCNT] = evt.word_count_bad;
      set_bits[MBS_B_SYNC] = evt.status_data_sync ||
                             evt.data_cmd_sync;
      set_bits[MBS_B_INV]  = evt.word_error;
      set_bits[MBS_B_PAIR] = (state_q != MBS_IDLE) &&
                             (evt.resp_addr_bad ||
                              evt.resp_status_bad ||
                              early_resp);
      set_bits[MBS_B_FOLL] = evt.cmd2_bad;
      set_bits[MBS_B_FORM] = evt.cmd_undefined ||
                             (!bc_off && evt.bcast_mode_forbidden);
      set_bits[MBS_B_FMT]  = evt.format_err;
      set_bits[MBS_B_TOUT] = evt.timeout_err && !mon_mode;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         word_q <= MBS_STATUS_RST;
      end else if (evt.msg_start) begin
         word_q <= MBS_STATUS_RST | set_bits;
      end else if (evt.msg_end) begin
         word_q <= word_q | set_bits;
         word_q[MBS_B_DONE] <= 1'b1;
         if (mon_mode)
            word_q[MBS_B_LOOP] <= evt.msg_valid;
         if ((wrap_pend_q || (evt.data_write && ptr_at_top)) &&
             (!rollover_on_valid_only || evt.msg_valid))
            word_q[MBS_B_ROLL] <= 1'b1;
         if ((word_q[MBS_B_FMT] | word_q[MBS_B_TOUT] |
              word_q[MBS_B_LOOP] | set_bits[MBS_B_FMT] |
              set_bits[MBS_B_TOUT] | set_bits[MBS_B_LOOP]) && !mon_mode)
            word_q[MBS_B_SUM] <= 1'b1;
         else if (mon_mode && (word_q[MBS_B_FMT] | word_q[MBS_B_TOUT] |
                  set_bits[MBS_B_FMT] | set_bits[MBS_B_TOUT]))
            word_q[MBS_B_SUM] <= 1'b1;
      end else begin
         word_q <= word_q | set_bits;
         if (!mon_mode && (set_bits[MBS_B_LOOP] | set_bits[MBS_B_FMT] |
                           set_bits[MBS_B_TOUT]))
            word_q[MBS_B_SUM] <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_word <= MBS_STATUS_RST;
         status_wr   <= 1'b0;
         end_q       <= 1'b0;
      end else begin
         // copy one cycle after msg_end so the closing bits are included
         end_q     <= evt.msg_end;
         status_wr <= end_q;
         if (end_q)
            status_word <= word_q;
      end
   end

   // ----------------------------------------------------------------
   // circular buffer pointer
   // ----------------------------------------------------------------
   // with valid-only rollover, an invalid message rewinds to its base
   // so it is overwritten, and its pending wrap is cleared at msg_end without setting the rollover bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ptr_q       <= '0;
         msg_base_q  <= '0;
         wrap_pend_q <= 1'b0;
      end else begin
         if (evt.msg_start) begin
            msg_base_q  <= ptr_q;
            wrap_pend_q <= 1'b0;
         end
         if (evt.data_write) begin
            if (ptr_at_top) begin
               ptr_q       <= '0;
               wrap_pend_q <= 1'b1;
            end else begin
               ptr_q <= ptr_q + 1'b1;
            end
         end
         if (evt.msg_end) begin
            wrap_pend_q <= 1'b0;
            if (rollover_on_valid_only && !evt.msg_valid)
               ptr_q <= msg_base_q;
         end
      end
   end
   assign buf_ptr = ptr_q;

   // ----------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------
   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_q && !s_axi_bvalid;
   assign wr_fire       = aw_q && w_q && !s_axi_bvalid;
   assign s_axi_bresp   = 2'b00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q         <= 1'b0;
         w_q          <= 1'b0;
         awa_q        <= 8'h00;
         wd_q         <= 32'h0000_0000;
         ws_q         <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q  <= 1'b1;
            awa_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q  <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // config and mask registers, byte-enable aware
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q  <= MBS_CONFIG_RST;
         mask_q <= 16'h0000;
      end else if (wr_fire) begin
         for (int i = 0; i < 4; i++) begin
            if (ws_q[i] && awa_q == MBS_OFS_CONFIG)
               cfg_q[i*8 +: 8] <= wd_q[i*8 +: 8];
         end
         for (int i = 0; i < 2; i++) begin
            if (ws_q[i] && awa_q == MBS_OFS_MASK)
               mask_q[i*8 +: 8] <= wd_q[i*8 +: 8];
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupt status: sticky per bit, set wins over write-one clear
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_q <= 16'h0000;
      end else begin
         logic [15:0] clr;
         logic [15:0] ev;
         clr = 16'h0000;
         ev  = set_bits;
         ev[MBS_B_DONE] = evt.msg_end;
         if (wr_fire && awa_q == MBS_OFS_IRQ) begin
            clr[7:0]  = ws_q[0] ? wd_q[7:0]  : 8'h00;
            clr[15:8] = ws_q[1] ? wd_q[15:8] : 8'h00;
         end
         irq_q <= (irq_q & ~clr) | ev;
      end
   end
   assign irq = |(irq_q & mask_q);

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;
   assign s_axi_rresp   = 2'b00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         unique case (s_axi_araddr)
            MBS_OFS_STATUS: s_axi_rdata <= {16'h0000, word_q};
            MBS_OFS_CONFIG: s_axi_rdata <= cfg_q;
            MBS_OFS_IRQ:    s_axi_rdata <= {16'h0000, irq_q};
            MBS_OFS_MASK:   s_axi_rdata <= {16'h0000, mask_q};
            MBS_OFS_BUFPTR: s_axi_rdata <= 32'(ptr_q);
            default:        s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// *** hdl/mbs_pkg.sv ***
// package for the message block status error generator
// assumes one clock domain and an axi4-lite register bus
// Contract
// - rt mode: loopback word invalid or mismatching sets loopback_error_flag
// - monitor mode: bit 8 is one for valid message, zero otherwise
// - global circular buffer passing its upper bound sets buffer_rollover_flag
// - rollover_on_valid_only: roll over only after a valid message
// - monitor mode: buffer size comes from monitor_buffer_size_field
// - rt mode: illegalized command sets forbidden_command_flag
// - wrong data word count on listed message types sets word_count_fault
// - status with data sync or data with command sync sets sync_error_flag
// - sync, manchester, bit count or parity error sets invalid_word_flag
// - rt-to-rt status address mismatch sets transfer_pair_error
// - with gap_check_on, response under 4 us sets transfer_pair_error
// - rt-to-rt invalid status or wrong sync sets transfer_pair_error
// - bad second rt-to-rt command sets followup_command_fault
// - undefined command word sets illformed_command_flag
// - broadcast allowed: forbidden broadcast mode command is undefined
// - error_summary_flag one when format, timeout or loopback bit set
// - message_done_flag set at message completion regardless of errors
package mbs_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] MBS_OFS_STATUS = 8'h00;
   localparam logic [7:0] MBS_OFS_CONFIG = 8'h04;
   localparam logic [7:0] MBS_OFS_IRQ    = 8'h08;
   localparam logic [7:0] MBS_OFS_MASK   = 8'h0C;
   localparam logic [7:0] MBS_OFS_BUFPTR = 8'h10;
   // ----------------------------------------------------------------
   // status word bit positions
   // ----------------------------------------------------------------
   localparam int MBS_B_DONE  = 15;
   localparam int MBS_B_SUM   = 12;
   localparam int MBS_B_FMT   = 10;
   localparam int MBS_B_TOUT  = 9;
   localparam int MBS_B_LOOP  = 8;
   localparam int MBS_B_ROLL  = 7;
   localparam int MBS_B_ILL   = 6;
   localparam int MBS_B_WCNT  = 5;
   localparam int MBS_B_SYNC  = 4;
   localparam int MBS_B_INV   = 3;
   localparam int MBS_B_PAIR  = 2;
   localparam int MBS_B_FOLL  = 1;
   localparam int MBS_B_FORM  = 0;
   // ----------------------------------------------------------------
   // config bit positions and resets
   // ----------------------------------------------------------------
   localparam int MBS_C_MON     = 0;
   localparam int MBS_C_ROLLOVER_ON_VALID_ONLY   = 1;
   localparam int MBS_C_GAP     = 2;
   localparam int MBS_C_BCOFF   = 3;
   localparam int MBS_C_SIZE_LO = 8;
   localparam logic [31:0] MBS_CONFIG_RST = 32'h0000_0000;
   localparam logic [15:0] MBS_STATUS_RST = 16'h0000;
   // ----------------------------------------------------------------
   // timing and buffer size base
   // ----------------------------------------------------------------
   localparam int MBS_CLK_MHZ   = 250;
   localparam int MBS_GAP_MIN_NS = 4000;
   localparam int MBS_GAP_CYC   = (MBS_GAP_MIN_NS * MBS_CLK_MHZ + 999) / 1000;
   localparam int MBS_BUF_BASE  = 256;
   // ----------------------------------------------------------------
   // protocol engine event bundle
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       msg_start;
      logic       msg_end;
      logic       msg_valid;
      logic       rt_to_rt;
      logic       loop_word_bad;
      logic       loop_mismatch;
      logic       illegal_cmd;
      logic       word_count_bad;
      logic       status_data_sync;
      logic       data_cmd_sync;
      logic       word_error;
      logic       resp_addr_bad;
      logic       resp_status_bad;
      logic       resp_sync_seen;
      logic       cmd2_bad;
      logic       cmd_undefined;
      logic       bcast_mode_forbidden;
      logic       format_err;
      logic       timeout_err;
      logic       data_write;
   } mbs_evt_s;
   typedef enum logic [1:0] {MBS_IDLE, MBS_MSG, MBS_GAPWAIT} mbs_state_e;
endpackage

// *** tb/mbs_status_chk.sv ***
// assertions on the ports of the message block status generator
// assumes a bind into mbs_status_gen and a single clock domain
module mbs_status_chk
   import mbs_pkg::*;
(
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // protocol side
   input wire mbs_evt_s    evt,
   input wire logic [15:0] status_word,
   input wire logic        status_wr
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // events seen during the current message
   // ----------------------------------------------------------------
   logic [7:0] seen_q;
   logic [7:0] seen_d;
   // opening cycle events are kept for all eight bits, though the generator drops rt_to_rt and pair errors there
   always_comb begin
      seen_d = evt.msg_start ? 8'h00 : seen_q;
      seen_d = seen_d | {evt.illegal_cmd, evt.word_count_bad,
         evt.status_data_sync | evt.data_cmd_sync, evt.word_error,
         evt.rt_to_rt, evt.resp_addr_bad | evt.resp_status_bad,
         evt.cmd2_bad, evt.cmd_undefined};
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seen_q <= 8'h00;
      end else begin
         seen_q <= seen_d;
      end
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_wr_after_end; evt.msg_end |=> ##1 status_wr; endproperty
   a_wr_after_end: assert property (p_wr_after_end)
      else $error("no status write after message end");
   property p_wr_cause;
      status_wr |-> $past(evt.msg_end, 2) && status_word[15];
   endproperty
   a_wr_cause: assert property (p_wr_cause)
      else $error("status write without message end or done bit");
   property p_summary; status_wr && (status_word[10] || status_word[9])
      |-> status_word[12]; endproperty
   a_summary: assert property (p_summary)
      else $error("summary bit clear with format or timeout error");
   property p_ill; status_wr |-> status_word[6] == seen_q[7]; endproperty
   a_ill: assert property (p_ill)
      else $error("forbidden command bit wrong");
   property p_wcnt; status_wr |-> status_word[5] == seen_q[6]; endproperty
   a_wcnt: assert property (p_wcnt)
      else $error("word count bit wrong");
   property p_sync; status_wr |-> status_word[4] == seen_q[5]; endproperty
   a_sync: assert property (p_sync)
      else $error("sync error bit wrong");
   property p_inv; status_wr |-> status_word[3] == seen_q[4]; endproperty
   a_inv: assert property (p_inv)
      else $error("invalid word bit wrong");
   property p_pair; status_wr && seen_q[3] && seen_q[2] |-> status_word[2];
   endproperty
   a_pair: assert property (p_pair)
      else $error("transfer pair error bit missing");
   property p_foll; status_wr |-> status_word[1] == seen_q[1]; endproperty
   a_foll: assert property (p_foll)
      else $error("follow-up command bit wrong");
   property p_form; status_wr && seen_q[0] |-> status_word[0]; endproperty
   a_form: assert property (p_form)
      else $error("ill-formed command bit missing");
   c_roll: cover property (status_wr && status_word[7]);
   c_gap: cover property (status_wr && status_word[2] && !seen_q[2]);
   c_mon: cover property (status_wr && status_word[8] && !status_word[12]);
endmodule

bind mbs_status_gen mbs_status_chk mbs_status_chk_i (.aclk(aclk),
   .aresetn(aresetn), .evt(evt), .status_word(status_word),
   .status_wr(status_wr));

// *** tb/mbs_engine_model.sv ***
// serial protocol engine stand-in: plays whole messages as event pulses
// assumes calls start just after a rising edge of aclk
module mbs_engine_model
   import mbs_pkg::*;
(
   // clock
   input wire logic aclk,
   // events towards the status generator
   output mbs_evt_s evt
);
   timeunit 1ns;
   timeprecision 1ps;
   initial evt = '0;
   // one assignment per cycle, so pulses never collide in a time step
   task automatic drive(input mbs_evt_s e);
      evt <= e;
      @(posedge aclk);
   endtask
   // err is a bit of the bundle, -1 none; gap -1 means no rt-to-rt leg
   task automatic send(input int err, nwr, gap, input logic ok);
      mbs_evt_s e;
      e = '0;
      e.msg_start = 1'b1;
      drive(e);
      if (gap >= 0) begin
         drive(20'h1_0000);
         repeat (gap - 1) drive('0);
         drive(20'h0_0040);
      end
      repeat (nwr) drive(20'h0_0001);
      e = '0;
      if (err >= 0) begin
         e[err] = 1'b1;
         drive(e);
      end
      e = '0;
      e.msg_end = 1'b1;
      e.msg_valid = ok;
      drive(e);
      evt <= '0;
   endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the message block status generator
// assumes the engine model drives evt and this module drives axi4-lite
module testbench
   import mbs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk, aresetn, status_wr, irq;
   mbs_evt_s    evt;
   logic [15:0] status_word, ex[14];
   logic [11:0] buf_ptr;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   int          fails, checks, eb[14];
   mbs_status_gen #(.BUF_PTR_W(12)) mbs_status_gen_i (.aclk, .aresetn, .evt,
      .status_word, .status_wr, .buf_ptr, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
   mbs_engine_model mbs_engine_model_i (.aclk, .evt);
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // ----------------------------------------------------------------
   // checking and bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic give_up();
      fails++;
      test_done();
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (n > 50) give_up();
      end while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (n > 50) give_up();
      end while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask
   // bits 14, 13 and 11 are outside this block's concern and masked off
   task automatic msg(input int err, nwr, gap, input logic ok,
                      input logic [15:0] exp);
      int n;
      n = 0;
      @(posedge aclk);
      mbs_engine_model_i.send(err, nwr, gap, ok);
      while (!status_wr) begin
         @(posedge aclk);
         n++;
         if (n > 8) give_up();
      end
      chk("status_word", {16'h0000, status_word & 16'h97FF}, {16'h0000, exp});
   endtask
   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      fails = 0;
      checks = 0;
      aresetn = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      eb = '{15, 14, 13, 12, 11, 10, 9, 8, 7, 5, 4, 3, 2, 1};
      ex = '{16'h9100, 16'h9100, 16'h8040, 16'h8020, 16'h8010, 16'h8010,
             16'h8008, 16'h8004, 16'h8004, 16'h8002, 16'h8001, 16'h8001,
             16'h9400, 16'h9200};
      do_reset();
      chk("irq", irq, 32'h0000_0000);
      axi_rd(MBS_OFS_CONFIG, rd);
      chk("config", rd, MBS_CONFIG_RST);
      axi_rd(MBS_OFS_STATUS, rd);
      chk("status", rd, {16'h0000, MBS_STATUS_RST});
      axi_rd(MBS_OFS_MASK, rd);
      chk("mask", rd, 32'h0000_0000);
      axi_wr(8'h20, 32'hFFFF_FFFF);
      axi_rd(8'h20, rd);
      chk("unmapped", rd, 32'h0000_0000);
      axi_wr(MBS_OFS_CONFIG, 32'h0000_070E);
      axi_rd(MBS_OFS_CONFIG, rd);
      chk("config", rd, 32'h0000_070E);
      axi_wr(MBS_OFS_CONFIG, 32'h0000_0000);
      for (int i = 0; i < 7; i++) begin
         msg(eb[i], 0, -1, 1, ex[i]);
      end
      for (int i = 7; i < 14; i++) begin
         msg(eb[i], 0, 1100, 1, ex[i]);
      end
      msg(-1, 0, -1, 1, 16'h8000);
      axi_rd(MBS_OFS_STATUS, rd);
      chk("status_reg", rd & 32'h0000_97FF, 32'h0000_8000);
      msg(4, 0, -1, 1, 16'h8001);
      axi_wr(MBS_OFS_CONFIG, 32'h0000_0004);
      msg(-1, 0, 900, 1, 16'h8004);
      msg(-1, 0, 1100, 1, 16'h8000);
      axi_wr(MBS_OFS_CONFIG, 32'h0000_0008);
      msg(3, 0, -1, 1, 16'h8000);
      axi_wr(MBS_OFS_CONFIG, 32'h0000_0001);
      msg(-1, 0, -1, 1, 16'h8100);
      msg(-1, 0, -1, 0, 16'h8000);
      chk("irq_masked", irq, 32'h0000_0000);
      axi_wr(MBS_OFS_MASK, 32'h0000_FFFF);
      axi_rd(MBS_OFS_MASK, rd);
      chk("irq_set", irq, 32'h0000_0001);
      axi_wr(MBS_OFS_IRQ, 32'h0000_FFFF);
      axi_rd(MBS_OFS_IRQ, rd);
      chk("irq_clr", {rd[31:1], irq}, 32'h0000_0000);
      axi_wr(MBS_OFS_CONFIG, 32'h0000_0000);
      msg(13, 0, -1, 1, 16'h8040);
      axi_rd(MBS_OFS_IRQ, rd);
      chk("irq_stat", rd, 32'h0000_8040);
      chk("irq_line", irq, 32'h0000_0001);
      // second reset mid-run also restarts the buffer pointer
      do_reset();
      chk("status_rst", status_word, 32'h0000_0000);
      axi_wr(MBS_OFS_CONFIG, 32'h0000_0101);
      msg(-1, 300, -1, 1, 16'h8100);
      msg(-1, 300, -1, 1, 16'h8180);
      axi_wr(MBS_OFS_CONFIG, 32'h0000_0103);
      msg(-1, 500, -1, 0, 16'h8000);
      msg(-1, 500, -1, 1, 16'h8180);
      test_done();
   end
endmodule
